// File: lsd_driver.sv
/*
  segment lcd driver: apb register file, base clock divider, backplane and frontplane
  level selects, ladder resistor and fast-charge control.
  assumes the oscillator reference arrives from another domain and is much slower than clock,
  and that stop_mode comes from logic on clock.
*/
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "lsd_consts.svh"

// Summary of operation
// - up to 25 frontplanes and 4 backplanes
// - shared pin is frontplane 0 or backplane 3
// - port pins need enable plus group enable
// - thirteen data registers, two frontplanes each
// - segment bit one on, zero off
// - disabled: all outputs at supply, ladder off
// - static duty drives backplane 0 only
// - backplane 3 only in quarter duty
// - enabled backplanes drive periodic duty waveforms
// - base clock divides the oscillator reference
// - frame length equals backplane count periods
// - frontplanes follow duty and segment bits
// - low current selects high resistance ladder
// - fast charge pulses low resistance at edges
// - pulse length base period over 32/64/128
// - four-bit contrast, zero is maximum
// - keeps running in wait mode
// - stop freezes unless oscillator runs in stop
// - stop leaves registers unchanged
// - duty codes static, third, quarter, unused
// - ladder follows low-current and fast-charge bits
// - reset clears the driver enable
module lsd_driver (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system
  input wire logic oscillator_ref_clock,
  input wire logic stop_mode,
  // panel drive levels
  output logic [2:0][1:0] backplane_out,
  output logic [24:1][1:0] frontplane_out,
  output logic [1:0] shared_plane_pin,
  output logic shared_plane_is_bp,
  output logic [24:1] frontplane_lcd_sel,
  // ladder
  output logic ladder_connect,
  output logic ladder_high_res,
  output logic [3:0] contrast_level
);
  import lsd_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) &&
                  (a <= `LSD_OFS_DATA_LAST);
  endfunction

  function automatic logic [1:0] bp_level(input logic selected, input logic stat, input logic h);
    if (stat) begin
      bp_level = h ? `LSD_LVL_VLCD3 : `LSD_LVL_VLCD;
    end else if (selected) begin
      bp_level = h ? `LSD_LVL_VLCD3 : `LSD_LVL_VLCD;
    end else begin
      bp_level = h ? `LSD_LVL_VLCD1 : `LSD_LVL_VLCD2;
    end
  endfunction

  function automatic logic [1:0] fp_level(input logic on, input logic stat, input logic h);
    if (stat) begin
      if (on) begin
        fp_level = h ? `LSD_LVL_VLCD : `LSD_LVL_VLCD3;
      end else begin
        fp_level = h ? `LSD_LVL_VLCD3 : `LSD_LVL_VLCD;
      end
    end else if (on) begin
      fp_level = h ? `LSD_LVL_VLCD : `LSD_LVL_VLCD3;
    end else begin
      fp_level = h ? `LSD_LVL_VLCD2 : `LSD_LVL_VLCD1;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  lsd_state_t s_reg;
  lsd_state_t s_next;

  logic acc_wr;
  logic acc_setup;
  logic [3:0] data_idx;
  logic ref_tick;
  logic stat_duty;
  logic quarter;
  logic [1:0] last_phase;
  logic [14:0] ratio;
  logic [14:0] half_len;
  logic [14:0] pos;
  logic [14:0] pulse_len;
  logic [3:0] charge_shift;
  logic half_sel;
  logic seg_on;
  logic [4:0] fp_n;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);

  always_comb begin
    s_next = s_reg;
    acc_wr = psel && penable && pwrite && pstrb[0] && addr_mapped(paddr);
    acc_setup = psel && !penable;
    data_idx = 4'((paddr - `LSD_OFS_DATA0) >> 2);
    ref_tick = s_reg.osc_sync[1] && !s_reg.osc_sync[2];
    stat_duty = (s_reg.duty != `LSD_DUTY_THIRD) && (s_reg.duty != `LSD_DUTY_QUARTER);
    quarter = (s_reg.duty == `LSD_DUTY_QUARTER);
    seg_on = 1'b0;
    fp_n = 5'h00;

    // ----------------------------------------
    // oscillator synchroniser
    // ----------------------------------------
    s_next.osc_sync = {s_reg.osc_sync[1:0], oscillator_ref_clock};

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (acc_wr) begin
      case (paddr)
        `LSD_OFS_CTRL: begin
          s_next.en = pwdata[`LSD_CTRL_EN];
          s_next.fc = pwdata[`LSD_CTRL_FC];
          s_next.lc = pwdata[`LSD_CTRL_LC];
          s_next.contrast = pwdata[`LSD_CTRL_CON_LSB +: 4];
        end
        `LSD_OFS_CLK: begin
          s_next.fcctl = pwdata[`LSD_CLK_FCCTL_LSB +: 2];
          s_next.duty = pwdata[`LSD_CLK_DUTY_LSB +: 2];
          s_next.divsel = pwdata[`LSD_CLK_DIV_LSB +: 3];
        end
        `LSD_OFS_CFG: begin
          s_next.pe = pwdata[`LSD_CFG_PORTE];
          s_next.pd = pwdata[`LSD_CFG_PORTD];
          s_next.pc = pwdata[`LSD_CFG_PORTC];
          s_next.osc_stop = pwdata[`LSD_CFG_OSC_STOP];
        end
        `LSD_OFS_STATUS: begin
        end
        default: begin
          s_next.seg[data_idx] = pwdata[7:0];
        end
      endcase
    end

    // ----------------------------------------
    // read data, captured in the setup cycle
    // ----------------------------------------
    if (acc_setup) begin
      s_next.prdata = 32'h0000_0000;
      if (addr_mapped(paddr)) begin
        case (paddr)
          `LSD_OFS_CTRL: begin
            s_next.prdata[`LSD_CTRL_EN] = s_reg.en;
            s_next.prdata[`LSD_CTRL_FC] = s_reg.fc;
            s_next.prdata[`LSD_CTRL_LC] = s_reg.lc;
            s_next.prdata[`LSD_CTRL_CON_LSB +: 4] = s_reg.contrast;
          end
          `LSD_OFS_CLK: begin
            s_next.prdata[`LSD_CLK_FCCTL_LSB +: 2] = s_reg.fcctl;
            s_next.prdata[`LSD_CLK_DUTY_LSB +: 2] = s_reg.duty;
            s_next.prdata[`LSD_CLK_DIV_LSB +: 3] = s_reg.divsel;
          end
          `LSD_OFS_CFG: begin
            s_next.prdata[`LSD_CFG_PORTE] = s_reg.pe;
            s_next.prdata[`LSD_CFG_PORTD] = s_reg.pd;
            s_next.prdata[`LSD_CFG_PORTC] = s_reg.pc;
            s_next.prdata[`LSD_CFG_OSC_STOP] = s_reg.osc_stop;
          end
          `LSD_OFS_STATUS: begin
            s_next.prdata[1:0] = 2'(s_reg.run);
            s_next.prdata[3:2] = s_reg.phase;
            s_next.prdata[4] = s_reg.ladder_hi;
            s_next.prdata[5] = s_reg.shared_is_bp;
          end
          default: begin
            s_next.prdata[7:0] = s_reg.seg[data_idx];
          end
        endcase
      end
    end

    // ----------------------------------------
    // run state
    // ----------------------------------------
    // stop freezes without oscillator
    case (s_reg.run)
      st_off: begin
        if (s_reg.en) begin
          s_next.run = st_run;
        end
      end
      st_run: begin
        if (!s_reg.en) begin
          s_next.run = st_off;
        end else if (stop_mode && !s_reg.osc_stop) begin
          s_next.run = st_hold;
        end
      end
      st_hold: begin
        if (!s_reg.en) begin
          s_next.run = st_off;
        end else if (!stop_mode || s_reg.osc_stop) begin
          s_next.run = st_run;
        end
      end
      default: begin
        s_next.run = st_off;
      end
    endcase

    // ----------------------------------------
    // base clock divider and phase
    // ----------------------------------------
    // base clock from reference
    ratio = `LSD_BASE_RATIO_MIN << s_reg.divsel;
    half_len = ratio >> 1;
    pos = s_reg.div_cnt & (half_len - 15'h0001);
    half_sel = (s_reg.div_cnt & half_len) != 15'h0000;
    last_phase = quarter ? 2'h3 : (stat_duty ? 2'h0 : 2'h2);
    if (s_reg.run == st_off) begin
      s_next.div_cnt = 15'h0000;
      s_next.phase = 2'h0;
    end else if (s_reg.run == st_run && ref_tick) begin
      if (s_reg.div_cnt >= ratio - 15'h0001) begin
        s_next.div_cnt = 15'h0000;
        s_next.phase = (s_reg.phase >= last_phase) ? 2'h0 : s_reg.phase + 2'h1;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 15'h0001;
      end
    end

    // ----------------------------------------
    // ladder control
    // ----------------------------------------
    // pulse length select
    charge_shift = `LSD_CHARGE_SHIFT_MIN +
                   4'((s_reg.fcctl > `LSD_CHARGE_SEL_MAX) ? `LSD_CHARGE_SEL_MAX : s_reg.fcctl);
    pulse_len = ratio >> charge_shift;
    s_next.ladder_on = s_reg.en;
    if (!s_reg.lc) begin
      s_next.ladder_hi = 1'b0;
    end else if (!s_reg.fc) begin
      s_next.ladder_hi = 1'b1;
    end else begin
      s_next.ladder_hi = !(pos < pulse_len);
    end

    // ----------------------------------------
    // pin function select
    // ----------------------------------------
    // port group enables
    for (int i = 1; i < `LSD_NUM_FP; i++) begin
      if (i <= 2) begin
        s_next.fp_sel[i] = s_reg.en;
      end else if (i <= 10) begin
        s_next.fp_sel[i] = s_reg.en && s_reg.pe;
      end else if (i <= 18) begin
        s_next.fp_sel[i] = s_reg.en && s_reg.pd;
      end else begin
        s_next.fp_sel[i] = s_reg.en && s_reg.pc;
      end
    end
    s_next.shared_is_bp = quarter;

    // ----------------------------------------
    // waveform levels
    // ----------------------------------------
    if (s_reg.run == st_off) begin
      s_next.bp_lvl = {3{`LSD_LVL_VLCD}};
      s_next.fp_lvl = {24{`LSD_LVL_VLCD}};
      s_next.shared_lvl = `LSD_LVL_VLCD;
    end else if (s_reg.run == st_run) begin
      for (int b = 0; b < 3; b++) begin
        if (stat_duty && b != 0) begin
          s_next.bp_lvl[b] = `LSD_LVL_VLCD;
        end else begin
          s_next.bp_lvl[b] = bp_level(s_reg.phase == 2'(b), stat_duty, half_sel);
        end
      end
      for (int f = 1; f < `LSD_NUM_FP; f++) begin
        fp_n = 5'(f);
        seg_on = s_reg.seg[fp_n[4:1]][{fp_n[0], s_reg.phase}];
        s_next.fp_lvl[f] = fp_level(seg_on, stat_duty, half_sel);
      end
      if (quarter) begin
        s_next.shared_lvl = bp_level(s_reg.phase == 2'h3, 1'b0, half_sel);
      end else begin
        seg_on = s_reg.seg[0][{1'b0, s_reg.phase}];
        s_next.shared_lvl = fp_level(seg_on, stat_duty, half_sel);
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // stop leaves registers intact
  always_ff @(posedge clock) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.run <= st_off;
      s_reg.bp_lvl <= {3{`LSD_LVL_VLCD}};
      s_reg.fp_lvl <= {24{`LSD_LVL_VLCD}};
      s_reg.shared_lvl <= `LSD_LVL_VLCD;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = s_reg.prdata;
  assign backplane_out = s_reg.bp_lvl;
  assign frontplane_out = s_reg.fp_lvl;
  assign shared_plane_pin = s_reg.shared_lvl;
  assign shared_plane_is_bp = s_reg.shared_is_bp;
  assign frontplane_lcd_sel = s_reg.fp_sel;
  assign ladder_connect = s_reg.ladder_on;
  assign ladder_high_res = s_reg.ladder_hi;
  assign contrast_level = s_reg.contrast;

endmodule

// File: lsd_consts.svh
/*
  register offsets, field positions, reset values and timing constants of the segment lcd driver.
  assumes inclusion by its bare name from the package and the driver module.
*/
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSD_OFS_CTRL 8'h00
`define LSD_OFS_CLK 8'h04
`define LSD_OFS_CFG 8'h08
`define LSD_OFS_STATUS 8'h0c
`define LSD_OFS_DATA0 8'h10
`define LSD_OFS_DATA_LAST 8'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define LSD_CTRL_EN 0
`define LSD_CTRL_FC 1
`define LSD_CTRL_LC 2
`define LSD_CTRL_CON_LSB 4
`define LSD_CLK_FCCTL_LSB 0
`define LSD_CLK_DUTY_LSB 2
`define LSD_CLK_DIV_LSB 4
`define LSD_CFG_PORTE 0
`define LSD_CFG_PORTD 1
`define LSD_CFG_PORTC 2
`define LSD_CFG_OSC_STOP 3

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define LSD_RST_BYTE 8'h00
`define LSD_DUTY_STATIC 2'h0
`define LSD_DUTY_THIRD 2'h1
`define LSD_DUTY_QUARTER 2'h2
`define LSD_LVL_VLCD 2'h3
`define LSD_LVL_VLCD1 2'h2
`define LSD_LVL_VLCD2 2'h1
`define LSD_LVL_VLCD3 2'h0

// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define LSD_NUM_FP 25
`define LSD_NUM_DATA 13
`define LSD_BASE_RATIO_MIN 15'h0080
`define LSD_CHARGE_SHIFT_MIN 4'h5
`define LSD_CHARGE_SEL_MAX 2'h2

`endif

// File: lsd_pkg.sv
/*
  types of the segment lcd driver: run states and the module state record.
  assumes lsd_consts.svh is on the include path.
*/
`include "lsd_consts.svh"

package lsd_pkg;

  typedef enum logic [1:0] {
    st_off,
    st_run,
    st_hold
  } lsd_run_t;

  typedef struct packed {
    lsd_run_t run;
    logic [2:0] osc_sync;
    logic [14:0] div_cnt;
    logic [1:0] phase;
    logic en;
    logic fc;
    logic lc;
    logic [3:0] contrast;
    logic [1:0] fcctl;
    logic [1:0] duty;
    logic [2:0] divsel;
    logic pe;
    logic pd;
    logic pc;
    logic osc_stop;
    logic [12:0][7:0] seg;
    logic [31:0] prdata;
    logic [2:0][1:0] bp_lvl;
    logic [24:1][1:0] fp_lvl;
    logic [1:0] shared_lvl;
    logic shared_is_bp;
    logic [24:1] fp_sel;
    logic ladder_on;
    logic ladder_hi;
  } lsd_state_t;

endpackage

// File: lsd_assertions.sv
/*
  checker for the segment lcd driver: shadows register writes, checks pin levels.
  assumes binding into lsd_driver, writes gated by pstrb[0].
*/
`timescale 1ns/1ps
`include "lsd_consts.svh"
module lsd_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // system
  input wire logic stop_mode,
  // outputs
  input wire logic [2:0][1:0] backplane_out,
  input wire logic [24:1][1:0] frontplane_out,
  input wire logic [1:0] shared_plane_pin,
  input wire logic shared_plane_is_bp,
  input wire logic [24:1] frontplane_lcd_sel,
  input wire logic ladder_connect,
  input wire logic ladder_high_res,
  input wire logic [3:0] contrast_level
);
  logic [7:0] ctrl_reg, clk_reg, cfg_reg;
  logic en_s, fc_s, lc_s;
  assign en_s = ctrl_reg[0];
  assign fc_s = ctrl_reg[1];
  assign lc_s = ctrl_reg[2];
  // --------
  // register shadow
  // --------
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_reg <= 8'h00;
      clk_reg <= 8'h00;
      cfg_reg <= 8'h00;
    end else if (psel && penable && pwrite && pstrb[0]) begin
      if (paddr == `LSD_OFS_CTRL) ctrl_reg <= pwdata[7:0];
      if (paddr == `LSD_OFS_CLK) clk_reg <= pwdata[7:0];
      if (paddr == `LSD_OFS_CFG) cfg_reg <= pwdata[7:0];
    end
  end
  // --------
  // properties
  // --------
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  property p_off_supply;
    !ladder_connect [*3] |-> (&backplane_out) && (&frontplane_out) && (&shared_plane_pin);
  endproperty
  a_off_supply: assert property (p_off_supply) else $error("levels off supply while disabled");
  property p_ladder_en;
    ladder_connect == $past(en_s);
  endproperty
  a_ladder_en: assert property (p_ladder_en) else $error("ladder connect not following enable");
  property p_static_bp;
    clk_reg[3:2] != 2'h1 && clk_reg[3:2] != 2'h2 && $stable(clk_reg) && $past(clk_reg, 2) == clk_reg
      |-> (&backplane_out[2:1]);
  endproperty
  a_static_bp: assert property (p_static_bp) else $error("unused backplane driven in static");
  property p_shared;
    $stable(clk_reg) && $past(clk_reg, 2) == clk_reg |-> shared_plane_is_bp == (clk_reg[3:2] == 2'h2);
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin role wrong");
  property p_ladder_sel;
    en_s && ladder_connect && $past(ctrl_reg, 2) == ctrl_reg && !(lc_s && fc_s) |-> ladder_high_res == lc_s;
  endproperty
  a_ladder_sel: assert property (p_ladder_sel) else $error("ladder resistance wrong");
  property p_contrast;
    $stable(ctrl_reg) && $past(ctrl_reg, 2) == ctrl_reg |-> contrast_level == ctrl_reg[7:4];
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast code wrong");
  property p_pin_sel;
    $past(ctrl_reg, 2) == ctrl_reg && $past(cfg_reg, 2) == cfg_reg |-> frontplane_lcd_sel ==
      {{6{en_s & cfg_reg[2]}}, {8{en_s & cfg_reg[1]}}, {8{en_s & cfg_reg[0]}}, {2{en_s}}};
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pin function select wrong");
  property p_charge;
    en_s && lc_s && fc_s && $past(fc_s, 8) && $fell(ladder_high_res) |-> !ladder_high_res [*3];
  endproperty
  a_charge: assert property (p_charge) else $error("charge pulse too short");
  property p_hold;
    (stop_mode && !cfg_reg[3] && ladder_connect) [*4]
      |-> $stable(backplane_out) && $stable(frontplane_out) && $stable(shared_plane_pin);
  endproperty
  a_hold: assert property (p_hold) else $error("levels moved in stop");
  c_quarter: cover property (shared_plane_is_bp && ladder_connect);
  c_charge: cover property (fc_s && $fell(ladder_high_res));
  c_hold: cover property (stop_mode && !cfg_reg[3] && ladder_connect);
endmodule

bind lsd_driver lsd_assertions u_chk (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .stop_mode(stop_mode), .backplane_out(backplane_out),
  .frontplane_out(frontplane_out), .shared_plane_pin(shared_plane_pin),
  .shared_plane_is_bp(shared_plane_is_bp), .frontplane_lcd_sel(frontplane_lcd_sel),
  .ladder_connect(ladder_connect), .ladder_high_res(ladder_high_res), .contrast_level(contrast_level)
);

// File: lsd_panel.sv
/*
  passive glass model: one frontplane against four backplanes, per-frame summary.
  assumes frames start where backplane 0 rises to supply.
*/
`timescale 1ns/1ps
module lsd_panel (
  // clock
  input wire logic clock,
  // drive levels
  input wire logic [2:0][1:0] backplane_out,
  input wire logic [1:0] fp_level,
  input wire logic [1:0] shared_plane_pin,
  input wire logic shared_plane_is_bp,
  // frame summary
  output logic [3:0] shown,
  output int frame_cycles,
  output int frame_balance,
  output int frames
);
  logic [3:0][1:0] bp;
  logic [3:0] on_now, lit;
  logic [1:0] last_bp0 = 2'h3;
  int cnt, acc, d;
  always_comb begin
    bp = {shared_plane_is_bp ? shared_plane_pin : 2'h3, backplane_out};
    for (int b = 0; b < 4; b++) on_now[b] = (bp[b] ^ fp_level) == 2'h3 && bp[b] != 2'h1 && bp[b] != 2'h2;
    d = int'(bp[0]) - int'(fp_level);
  end
  always @(posedge clock) begin
    if (bp[0] == 2'h3 && last_bp0 != 2'h3) begin
      shown <= lit;
      frame_cycles <= cnt;
      frame_balance <= acc;
      frames <= frames + 1;
      cnt <= 1;
      acc <= d;
      lit <= on_now;
    end else begin
      cnt <= cnt + 1;
      acc <= acc + d;
      lit <= lit | on_now;
    end
    last_bp0 <= bp[0];
  end
endmodule

// File: test_lcd_segment_driver.sv
/*
  testbench of the segment lcd driver: apb register tasks, waveform and ladder checks.
  assumes lsd_panel on frontplane 1 and a reference at a quarter of the clock rate.
*/
`timescale 1ns/1ps
`include "lsd_consts.svh"
module test_lcd_segment_driver;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_mode = 1'b0, ref_clk = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, shared_plane_is_bp, ladder_connect, ladder_high_res;
  logic [2:0][1:0] backplane_out;
  logic [24:1][1:0] frontplane_out;
  logic [1:0] shared_plane_pin;
  logic [24:1] frontplane_lcd_sel;
  logic [3:0] contrast_level, shown;
  logic [9:0] held;
  int frame_cycles, frame_balance, frames, n_errors, n_compared;
  logic [1:0] duty [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
  logic [3:0] pat [4] = '{4'ha, 4'h5, 4'h1, 4'h1};
  logic [3:0] mask [4] = '{4'hf, 4'h7, 4'h1, 4'h1};
  int dv [4] = '{0, 1, 0, 2};
  int ph [4] = '{4, 3, 1, 1};
  logic [2:0] cfgv [3] = '{3'h0, 3'h2, 3'h7};
  logic [23:0] selx [3] = '{24'h000003, 24'h03fc03, 24'hffffff};
  always #2.5 clock = ~clock;
  always #10 ref_clk = ~ref_clk;
  lsd_driver u_dut (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscillator_ref_clock(ref_clk), .stop_mode(stop_mode), .backplane_out(backplane_out),
    .frontplane_out(frontplane_out), .shared_plane_pin(shared_plane_pin),
    .shared_plane_is_bp(shared_plane_is_bp), .frontplane_lcd_sel(frontplane_lcd_sel),
    .ladder_connect(ladder_connect), .ladder_high_res(ladder_high_res), .contrast_level(contrast_level)
  );
  lsd_panel u_panel (
    .clock(clock), .backplane_out(backplane_out), .fp_level(frontplane_out[1]),
    .shared_plane_pin(shared_plane_pin), .shared_plane_is_bp(shared_plane_is_bp), .shown(shown),
    .frame_cycles(frame_cycles), .frame_balance(frame_balance), .frames(frames)
  );
  // --------
  // tasks
  // --------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_frames(input int k);
    int t0, n;
    t0 = frames;
    n = 0;
    while (frames < t0 + k && n < 20000) begin
      @(posedge clock);
      n++;
    end
    check("frame wait", n < 20000, 1);
  endtask
  task finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // --------
  // tests
  // --------
  initial begin
    #450000;
    n_errors++;
    finish_test;
  end
  initial begin
    int c, e;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    apb(0, `LSD_OFS_CTRL, 0);
    check("ctrl reset", rd, 0);
    check("off levels", {ladder_connect, backplane_out, shared_plane_pin}, 9'h0ff);
    apb(0, 8'h44, 0);
    check("unmapped", err, 1);
    for (int i = 0; i < 4; i++) begin
      apb(1, `LSD_OFS_CTRL, 0);
      apb(1, `LSD_OFS_DATA0, {24'h0, pat[i], 4'h0});
      apb(1, `LSD_OFS_CLK, {3'(dv[i]), duty[i], 2'h0});
      apb(1, `LSD_OFS_CTRL, 1);
      wait_frames(2);
      check("frame length", frame_cycles, (512 << dv[i]) * ph[i]);
      check("segments", shown & mask[i], pat[i] & mask[i]);
      check("balance", frame_balance, 0);
      check("shared role", shared_plane_is_bp, duty[i] == 2'h2);
    end
    for (int l = 0; l < 2; l++) begin
      apb(1, `LSD_OFS_CTRL, 1 | (l << 2));
      repeat (2) @(posedge clock);
      check("ladder", ladder_high_res, l);
    end
    for (int k = 0; k < 4; k++) begin
      apb(1, `LSD_OFS_CLK, 8 | k);
      apb(1, `LSD_OFS_CTRL, 7);
      c = 0;
      while (ladder_high_res !== 1'b1 && c < 5000) begin @(posedge clock); c++; end
      while (ladder_high_res !== 1'b0 && c < 5000) begin @(posedge clock); c++; end
      c = 0;
      while (ladder_high_res === 1'b0 && c < 5000) begin @(posedge clock); c++; end
      e = 4 * (128 >> (5 + (k > 2 ? 2 : k)));
      check("charge pulse", c >= e - 1 && c <= e + 1, 1);
    end
    for (int j = 0; j < 3; j++) begin
      apb(1, `LSD_OFS_CFG, cfgv[j]);
      repeat (2) @(posedge clock);
      check("pin select", frontplane_lcd_sel, selx[j]);
    end
    apb(1, `LSD_OFS_CTRL, 32'hf1);
    repeat (2) @(posedge clock);
    check("contrast", contrast_level, 4'hf);
    stop_mode <= 1'b1;
    repeat (4) @(posedge clock);
    held = {backplane_out, frontplane_out[1], shared_plane_pin};
    repeat (600) @(posedge clock);
    check("held levels", {backplane_out, frontplane_out[1], shared_plane_pin}, held);
    apb(0, `LSD_OFS_STATUS, 0);
    check("hold state", rd[1:0], 2'h2);
    apb(0, `LSD_OFS_CTRL, 0);
    check("ctrl kept", rd, 32'hf1);
    apb(1, `LSD_OFS_CFG, 32'hf);
    e = frames;
    wait_frames(1);
    check("runs in stop", frames > e, 1);
    stop_mode <= 1'b0;
    apb(1, `LSD_OFS_CTRL, 0);
    repeat (4) @(posedge clock);
    check("disabled", {frontplane_lcd_sel, backplane_out, ladder_connect}, 31'h7e);
    check("fp supply", &frontplane_out, 1);
    finish_test;
  end
endmodule
